// [hw/ssp_host_port.sv]
// Serial slave port: two-wire bus and four/three-wire SPI on shared pads,
// giving a host byte access to the register bank.
// Assumes bus clocks far slower than clock_i; the bank answers a read
// strobe with reg_rd_data_i in the following cycle.
//
// Function
// - Chip-select high means two-wire, low means SPI
// - Bus address 101110 plus address-select pad bit
// - First seven bits matched, eighth is direction
// - Receiver pulls data low through acknowledge clock
// - Increment bit advances index after each byte
// - Master acks reads except last; device acks writes
// - Bytes of eight bits, msb first, unlimited
// - Receiver may stretch clock low to wait; port never drives the clock
// - Unmatched address leaves data line high
// - Works at fast-mode and standard-mode bus rates
// - SPI data changes falling, sampled rising
// - SPI frame sixteen clocks, eight more per byte
// - SPI bit0 direction, bits1-7 index, then data
// - SPI read drives output from bit 8
// - SPI blocks increment index or repeat it
// - Three-wire bit shares one data pin for reads
// - Clock pad shared; output pad doubles as address-select
// - Incremented reads wrap index 2C back to 28
`timescale 1ns/10ps
`default_nettype none

`include "ssp_params.svh"

module ssp_host_port (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic serial_port_clock_i,     // Shared clock pad
   input wire logic serial_data_i,           // Data pad level (two-wire data, SPI input)
   input wire logic cs_i,                    // Chip select pad
   input wire logic addr_select_pad_i,       // Output pad level, read as address select
   input wire logic three_wire_select_bit_i, // Control-one interface mode bit
   input wire logic addr_inc_en_i,           // Control-two index increment bit
   input wire logic [7:0] reg_rd_data_i,     // Bank read data, cycle after strobe
   output logic serial_data_o,
   output logic serial_data_oe_o,
   output logic serial_out_o,
   output logic serial_out_oe_o,
   output ssp_pkg::ssp_reg_req_type reg_req_o,
   output logic spi_mode_o,
   output logic i2c_addressed_o
);
   import ssp_pkg::*;

   // Synchronised pins
   logic scl_s;
   logic sda_s;
   logic cs_s;
   logic sel_s;
   // Delayed copies for edge finding
   logic scl_q;
   logic sda_q;
   logic cs_q;
   // Edge events
   logic scl_rise;
   logic scl_fall;
   logic cs_fall;
   logic bus_start;
   logic bus_stop;
   logic [7:0] rx_byte; // Shift register with the bit now arriving

   // Engine state and next values
   ssp_i2c_state_type state, next_state;
   ssp_i2c_state_type ack_ret, next_ack_ret; // Where to go after our acknowledge
   logic [3:0] bcnt, next_bcnt;               // Bits in current byte
   logic [7:0] shreg, next_shreg;             // Receive shift register
   logic [7:0] txreg, next_txreg;             // Transmit shift register
   logic [6:0] idx, next_idx;                 // Current register index
   logic inc_on, next_inc_on;                 // Index advances after access
   logic rd_load, next_rd_load;               // Capture bank data this cycle
   logic mack_ok, next_mack_ok;               // Master asked for another byte
   logic spi_first, next_spi_first;           // SPI command byte still arriving
   logic spi_rd, next_spi_rd;                 // SPI frame is a read
   logic sda_o, next_sda_o;
   logic sda_oe, next_sda_oe;
   logic so_o, next_so_o;
   logic so_oe, next_so_oe;
   ssp_reg_req_type req, next_req;
   logic spi_mode, next_spi_mode;
   logic addressed, next_addressed;

   // Pins cross into clock_i before anything reads them; the bus clock is
   // sampled like data, so its rate may fall anywhere up to fast mode
   ssp_sync_bit #(.RESET_VAL(`SSP_PIN_IDLE)) u_sync_scl (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .async_i(serial_port_clock_i), .sync_o(scl_s));
   ssp_sync_bit #(.RESET_VAL(`SSP_PIN_IDLE)) u_sync_sda (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .async_i(serial_data_i), .sync_o(sda_s));
   ssp_sync_bit #(.RESET_VAL(`SSP_PIN_IDLE)) u_sync_cs (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .async_i(cs_i), .sync_o(cs_s));
   ssp_sync_bit #(.RESET_VAL(`SSP_PIN_IDLE)) u_sync_sel (
      .clock_i(clock_i), .arst_n_i(arst_n_i), .async_i(addr_select_pad_i), .sync_o(sel_s));

   // Index step; wraps the output data block on reads only
   function automatic logic [6:0] step_idx(input logic [6:0] a, input logic inc, input logic rd);
      logic [6:0] r;
      r = a;
      if (inc) begin
         if (rd && (a == `SSP_WRAP_LAST)) begin
            r = `SSP_WRAP_FIRST;
         end else begin
            r = a + 7'h01;
         end
      end
      return r;
   endfunction : step_idx

   // Edge and condition detection on synchronised levels
   always_comb begin
      scl_rise = scl_s & ~scl_q;
      scl_fall = ~scl_s & scl_q;
      cs_fall = ~cs_s & cs_q;
      // Start and stop only count while chip-select keeps the bus two-wire
      bus_start = cs_s & cs_q & scl_s & scl_q & sda_q & ~sda_s;
      bus_stop = cs_s & cs_q & scl_s & scl_q & ~sda_q & sda_s;
      rx_byte = {shreg[6:0], sda_s};
   end

   // Protocol engine next state
   always_comb begin
      next_state = state;
      next_ack_ret = ack_ret;
      next_bcnt = bcnt;
      next_shreg = shreg;
      next_txreg = txreg;
      next_idx = idx;
      next_inc_on = inc_on;
      next_rd_load = req.rd; // Bank answers the cycle after the strobe
      next_mack_ok = mack_ok;
      next_spi_first = spi_first;
      next_spi_rd = spi_rd;
      next_sda_o = sda_o;
      next_sda_oe = sda_oe;
      next_so_o = so_o;
      next_so_oe = so_oe;
      next_req = '0; // Strobes last one cycle
      next_spi_mode = ~cs_s;
      next_addressed = 1'b0;
      // Bank data lands one cycle after a read strobe
      if (rd_load) begin
         next_txreg = reg_rd_data_i;
      end
      if (!cs_s) begin
         // SPI frame: two-wire engine held idle
         next_state = SSP_IDLE;
         if (cs_fall) begin
            // New frame: command byte first, nothing driven yet
            next_bcnt = 4'h0;
            next_spi_first = 1'b1;
            next_spi_rd = 1'b0;
            next_sda_oe = 1'b0;
            next_so_oe = 1'b0;
         end else if (scl_rise) begin
            // Sample on rising edge
            next_shreg = rx_byte;
            next_bcnt = {1'b0, bcnt[2:0] + 3'h1};
            if (bcnt[2:0] == 3'h7) begin
               // A full 8-clock block has arrived
               if (spi_first) begin
                  // Bit 0 direction, bits 1-7 index
                  next_spi_first = 1'b0;
                  next_spi_rd = rx_byte[7];
                  if (rx_byte[7]) begin
                     next_req.rd = 1'b1;
                     next_req.addr = rx_byte[6:0];
                     next_idx = step_idx(rx_byte[6:0], addr_inc_en_i, 1'b1);
                  end else begin
                     next_idx = rx_byte[6:0];
                  end
               end else if (spi_rd) begin
                  // Fetch next block while last bit is still out
                  next_req.rd = 1'b1;
                  next_req.addr = idx;
                  next_idx = step_idx(idx, addr_inc_en_i, 1'b1);
               end else begin
                  // Write block, msb first
                  next_req.wr = 1'b1;
                  next_req.addr = idx;
                  next_req.data = rx_byte;
                  next_idx = step_idx(idx, addr_inc_en_i, 1'b0);
               end
            end
         end else if (scl_fall && spi_rd) begin
            // Drive on falling edge from bit 8 onward
            if (three_wire_select_bit_i) begin
               next_sda_o = txreg[7];
               next_sda_oe = 1'b1;
               next_so_oe = 1'b0;
            end else begin
               next_so_o = txreg[7];
               next_so_oe = 1'b1;
               next_sda_oe = 1'b0;
            end
            next_txreg = {txreg[6:0], 1'b0};
         end
      end else begin
         // Two-wire mode: SPI outputs released, data pad open-drain only
         next_so_oe = 1'b0;
         next_sda_o = 1'b0;
         next_spi_rd = 1'b0;
         if (!cs_q) begin
            // Just left an SPI frame: drop any 3-wire drive
            next_sda_oe = 1'b0;
            next_state = SSP_IDLE;
         end else if (bus_start) begin
            // Start or repeated start, index kept for reads
            next_state = SSP_ADDR;
            next_bcnt = 4'h0;
            next_sda_oe = 1'b0;
         end else if (bus_stop) begin
            next_state = SSP_IDLE;
            next_sda_oe = 1'b0;
         end else begin
            case (state)
               SSP_ADDR, SSP_SUB, SSP_WDATA: begin
                  if (scl_rise) begin
                     next_shreg = rx_byte;
                     next_bcnt = bcnt + 4'h1;
                  end else if (scl_fall && (bcnt == `SSP_BITS_PER_BYTE)) begin
                     next_bcnt = 4'h0;
                     if (state == SSP_ADDR) begin
                        if (shreg[7:1] == {`SSP_BUS_ADDR_HI, sel_s}) begin
                           next_sda_oe = 1'b1;
                           next_state = SSP_ACK;
                           if (shreg[0]) begin
                              // Read: fetch first byte during our ack
                              next_ack_ret = SSP_RDATA;
                              next_req.rd = 1'b1;
                              next_req.addr = idx;
                              next_idx = step_idx(idx, inc_on, 1'b1);
                           end else begin
                              next_ack_ret = SSP_SUB;
                           end
                        end else begin
                           // Not ours: never pull the line
                           next_state = SSP_SKIP;
                        end
                     end else if (state == SSP_SUB) begin
                        next_idx = shreg[6:0];
                        next_inc_on = addr_inc_en_i | shreg[7];
                        next_sda_oe = 1'b1;
                        next_ack_ret = SSP_WDATA;
                        next_state = SSP_ACK;
                     end else begin
                        next_req.wr = 1'b1;
                        next_req.addr = idx;
                        next_req.data = shreg;
                        next_idx = step_idx(idx, inc_on, 1'b0);
                        next_sda_oe = 1'b1;
                        next_ack_ret = SSP_WDATA;
                        next_state = SSP_ACK;
                     end
                  end
               end
               SSP_ACK: begin
                  // Release after the acknowledge clock
                  if (scl_fall) begin
                     next_state = ack_ret;
                     next_bcnt = 4'h0;
                     next_sda_oe = 1'b0;
                     if (ack_ret == SSP_RDATA) begin
                        // First data bit goes out as the ack ends
                        next_sda_oe = ~txreg[7];
                        next_txreg = {txreg[6:0], 1'b0};
                        next_bcnt = 4'h1;
                     end
                  end
               end
               SSP_RDATA: begin
                  if (scl_fall) begin
                     if (bcnt == `SSP_BITS_PER_BYTE) begin
                        // Release for the master's acknowledge
                        next_sda_oe = 1'b0;
                        next_state = SSP_MACK;
                     end else begin
                        next_sda_oe = ~txreg[7]; // msb first
                        next_txreg = {txreg[6:0], 1'b0};
                        next_bcnt = bcnt + 4'h1;
                     end
                  end
               end
               SSP_MACK: begin
                  if (scl_rise) begin
                     next_mack_ok = ~sda_s;
                     if (!sda_s) begin
                        next_req.rd = 1'b1;
                        next_req.addr = idx;
                        next_idx = step_idx(idx, inc_on, 1'b1);
                     end
                  end else if (scl_fall) begin
                     if (mack_ok) begin
                        next_state = SSP_RDATA;
                        next_sda_oe = ~txreg[7];
                        next_txreg = {txreg[6:0], 1'b0};
                        next_bcnt = 4'h1;
                     end else begin
                        // No acknowledge: last byte, wait for stop
                        next_state = SSP_SKIP;
                     end
                  end
               end
               SSP_IDLE, SSP_SKIP: begin
                  next_sda_oe = 1'b0;
               end
               default: begin
                  next_state = SSP_IDLE;
                  next_sda_oe = 1'b0;
               end
            endcase
         end
         next_addressed = (next_state != SSP_IDLE) && (next_state != SSP_SKIP) && (next_state != SSP_ADDR);
      end
   end

   // Engine registers; edge copies ride along
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q <= `SSP_PIN_IDLE;
         sda_q <= `SSP_PIN_IDLE;
         cs_q <= `SSP_PIN_IDLE;
         state <= SSP_IDLE;
         ack_ret <= SSP_IDLE;
         bcnt <= 4'h0;
         shreg <= 8'h00;
         txreg <= 8'h00;
         idx <= 7'h00;
         inc_on <= 1'b1;
         rd_load <= 1'b0;
         mack_ok <= 1'b0;
         spi_first <= 1'b1;
         spi_rd <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
         so_o <= 1'b0;
         so_oe <= 1'b0;
         req <= '0;
         spi_mode <= 1'b0;
         addressed <= 1'b0;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         cs_q <= cs_s;
         state <= next_state;
         ack_ret <= next_ack_ret;
         bcnt <= next_bcnt;
         shreg <= next_shreg;
         txreg <= next_txreg;
         idx <= next_idx;
         inc_on <= next_inc_on;
         rd_load <= next_rd_load;
         mack_ok <= next_mack_ok;
         spi_first <= next_spi_first;
         spi_rd <= next_spi_rd;
         sda_o <= next_sda_o;
         sda_oe <= next_sda_oe;
         so_o <= next_so_o;
         so_oe <= next_so_oe;
         req <= next_req;
         spi_mode <= next_spi_mode;
         addressed <= next_addressed;
      end
   end

   // Outputs straight from flops; no clock stretching is ever needed
   // because the bank answers in one cycle
   always_comb begin
      serial_data_o = sda_o;
      serial_data_oe_o = sda_oe;
      serial_out_o = so_o;
      serial_out_oe_o = so_oe;
      reg_req_o = req;
      spi_mode_o = spi_mode;
      i2c_addressed_o = addressed;
   end
endmodule : ssp_host_port

`default_nettype wire

// [hw/ssp_params.svh]
// Constants for the serial host port: bus address, index wrap points,
// link timing figures and reset values.
// Assumes inclusion by bare name from the design files only.
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// Fixed upper six bits of the 7-bit bus address
`define SSP_BUS_ADDR_HI 6'h2E
// Bus address width and byte width
`define SSP_ADDR_W 7
`define SSP_BYTE_W 8
// Bit count that closes one byte
`define SSP_BITS_PER_BYTE 4'h8
// Index wrap during incremented reads of the output data block
`define SSP_WRAP_LAST 7'h2C
`define SSP_WRAP_FIRST 7'h28
// Fastest supported bus clock in kHz, and the logic clock in MHz
`define SSP_FAST_MODE_KHZ 400
`define SSP_CLK_MHZ 125
// Logic clocks per fastest bus clock period (rounded down)
`define SSP_BUS_PERIOD_CYC ((`SSP_CLK_MHZ * 1000) / `SSP_FAST_MODE_KHZ)
// Idle level of the synchronised pins (pulled up)
`define SSP_PIN_IDLE 1'b1

`endif

// [hw/ssp_pkg.sv]
// Types shared by the serial host port: register strobe carrier and
// the two-wire bus engine states.
// Assumes no surrounding logic; pure type definitions.
package ssp_pkg;

   // One register access toward the internal register bank
   typedef struct packed {
      logic wr;           // Single-cycle write strobe
      logic rd;           // Single-cycle read strobe
      logic [6:0] addr;   // Register index
      logic [7:0] data;   // Write data
   } ssp_reg_req_type;

   // Two-wire bus engine states
   typedef enum logic [2:0] {
      SSP_IDLE = 3'b000,  // Bus free or not for us
      SSP_ADDR = 3'b001,  // Receiving address byte
      SSP_SUB = 3'b010,   // Receiving register index byte
      SSP_WDATA = 3'b011, // Receiving write data
      SSP_ACK = 3'b100,   // Holding our acknowledge
      SSP_RDATA = 3'b101, // Shifting read data out
      SSP_MACK = 3'b110,  // Watching master acknowledge
      SSP_SKIP = 3'b111   // Not addressed, wait for start or stop
   } ssp_i2c_state_type;

endpackage : ssp_pkg

// [hw/ssp_sync_bit.sv]
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clock_i; only the second flop is read.
`timescale 1ns/10ps
`default_nettype none

module ssp_sync_bit #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta; // First stage, read only by the second

   // Both stages reset to the pin's idle level
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= RESET_VAL;
         sync_o <= RESET_VAL;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end
endmodule : ssp_sync_bit

`default_nettype wire

// [verif/ssp_host_port_sva.sv]
// Checker for the serial host port, watching its ports only.
// Assumes the bench changes the three-wire bit only between frames.
`timescale 1ns/10ps
`default_nettype none
module ssp_host_port_sva (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic cs_i,
   input wire logic three_wire_select_bit_i,
   input wire logic serial_data_o,
   input wire logic serial_data_oe_o,
   input wire logic serial_out_oe_o,
   input wire ssp_pkg::ssp_reg_req_type reg_req_o,
   input wire logic spi_mode_o
);
   import ssp_pkg::*;
   logic [2:0] cs_hi_cnt; // Cycles with cs high, saturating at 7
   // Pins lag by the synchroniser, so two-wire mode counts as settled only here
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cs_hi_cnt <= 3'h0;
      end else begin
         cs_hi_cnt <= !cs_i ? 3'h0 : cs_hi_cnt + {2'h0, cs_hi_cnt != 3'h7};
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_strobe;
      reg_req_o.wr || reg_req_o.rd;
   endsequence
   sequence s_ack_begin;
      $rose(serial_data_oe_o) && cs_hi_cnt == 3'h7;
   endsequence
   property p_mode_enter; $fell(cs_i) |-> ##[1:4] spi_mode_o; endproperty
   property p_so_idle; cs_hi_cnt == 3'h7 |-> !serial_out_oe_o && !spi_mode_o; endproperty
   property p_three_wire; three_wire_select_bit_i |-> !serial_out_oe_o; endproperty
   property p_four_wire; spi_mode_o && !three_wire_select_bit_i |-> !serial_data_oe_o; endproperty
   property p_pulse; s_strobe |=> !reg_req_o.wr && !reg_req_o.rd; endproperty
   property p_quiet; !reg_req_o.wr && !reg_req_o.rd |-> reg_req_o.addr == 7'h00 && reg_req_o.data == 8'h00;
   endproperty
   property p_ack_low; cs_hi_cnt == 3'h7 && serial_data_oe_o |-> !serial_data_o; endproperty
   property p_ack_hold; s_ack_begin |-> serial_data_oe_o [*8]; endproperty
   property p_so_start; $rose(serial_out_oe_o) |-> !cs_i && spi_mode_o; endproperty
   a_mode_enter: assert property (p_mode_enter) else $error("spi mode late");
   a_so_idle: assert property (p_so_idle) else $error("output pad busy in two-wire");
   a_three_wire: assert property (p_three_wire) else $error("output pad in three-wire");
   a_four_wire: assert property (p_four_wire) else $error("data pad driven in four-wire");
   a_pulse: assert property (p_pulse) else $error("strobe too long");
   a_quiet: assert property (p_quiet) else $error("idle strobe fields");
   a_ack_low: assert property (p_ack_low) else $error("two-wire drive high");
   a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
   a_so_start: assert property (p_so_start) else $error("output drive outside frame");
endmodule : ssp_host_port_sva
bind ssp_host_port ssp_host_port_sva chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .cs_i(cs_i),
   .three_wire_select_bit_i(three_wire_select_bit_i), .serial_data_o(serial_data_o),
   .serial_data_oe_o(serial_data_oe_o), .serial_out_oe_o(serial_out_oe_o), .reg_req_o(reg_req_o),
   .spi_mode_o(spi_mode_o));
`default_nettype wire

// [verif/ssp_host_model.sv]
// Host master model for two-wire and SPI transfers on the shared pads.
// Assumes the bench resolves pad levels; data_o high means released.
`timescale 1ns/10ps
`default_nettype none
module ssp_host_model (
   input wire logic clock_i,
   input wire logic data_pad_i, // Resolved data pad
   input wire logic out_pad_i,  // Resolved output pad
   output logic clk_pad_o,      // Shared clock pad
   output logic data_o,         // Master data drive
   output logic cs_o
);
   int q = 80; // Quarter bus period in clocks, about 390 kHz
   initial begin
      clk_pad_o = 1'b1;
      data_o = 1'b1;
      cs_o = 1'b1; // Two-wire unless a frame runs
   end
   // All pad changes land on falling clock edges
   task automatic wait_clk(input int n);
      repeat (n) @(negedge clock_i);
   endtask : wait_clk
   // Start, also usable as repeated start
   task automatic i2c_start();
      data_o = 1'b1;
      wait_clk(q);
      clk_pad_o = 1'b1;
      wait_clk(q);
      data_o = 1'b0;
      wait_clk(q);
      clk_pad_o = 1'b0;
      wait_clk(q);
   endtask : i2c_start
   // Stop closes every transaction
   task automatic i2c_stop();
      data_o = 1'b0;
      wait_clk(q);
      clk_pad_o = 1'b1;
      wait_clk(q);
      data_o = 1'b1;
      wait_clk(q);
   endtask : i2c_stop
   // Eight bits msb first, then the ack slot; send 1 to release
   task automatic i2c_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic ack_rx);
      logic [8:0] bits;
      logic [8:0] got;
      bits = {tx, ack_tx};
      for (int i = 8; i >= 0; i--) begin
         data_o = bits[i];
         wait_clk(q);
         clk_pad_o = 1'b1;
         wait_clk(q);
         got[i] = data_pad_i;
         wait_clk(q);
         clk_pad_o = 1'b0;
         wait_clk(q);
      end
      rx = got[8:1];
      ack_rx = got[0];
   endtask : i2c_byte
   // Frame open: cs low with clock parked high
   task automatic spi_begin();
      cs_o = 1'b0;
      wait_clk(4);
   endtask : spi_begin
   // Data changes on the fall; sampled late in the high phase for sync lag
   task automatic spi_byte(input logic [7:0] tx, input logic from_data, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         clk_pad_o = 1'b0;
         data_o = tx[i];
         wait_clk(4);
         clk_pad_o = 1'b1;
         wait_clk(3);
         rx[i] = from_data ? data_pad_i : out_pad_i;
         wait_clk(1);
      end
   endtask : spi_byte
   // Frame close after the last rise, then the data line released
   task automatic spi_end();
      wait_clk(4);
      cs_o = 1'b1;
      data_o = 1'b1;
      wait_clk(8);
   endtask : spi_end
endmodule : ssp_host_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the serial host port with a host model.
// Assumes a register bank answering one cycle after each read strobe.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import ssp_pkg::*;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sel = 1'b1;      // Address-select level behind the output pad
   logic three_w = 1'b0;
   logic inc_en = 1'b1;
   logic [7:0] rd_data = 8'h00;
   logic d_o, d_oe, so, so_oe, spi_mode, addressed, scl, m_data, cs, data_pad, out_pad;
   ssp_reg_req_type req;
   int errors = 0;
   int n_tests = 0;
   int seed = 91;
   logic [15:0] wq[$]; // Write strobes as {addr, data}
   logic [6:0] rq[$];  // Read strobe addresses
   always #4 clock = ~clock;
   // Pull-up on the data pad; the output pad doubles as select
   assign data_pad = d_oe ? (d_o & m_data) : m_data;
   assign out_pad = so_oe ? so : sel;
   ssp_host_port uut (.clock_i(clock), .arst_n_i(arst_n), .serial_port_clock_i(scl), .serial_data_i(data_pad),
      .cs_i(cs), .addr_select_pad_i(out_pad), .three_wire_select_bit_i(three_w), .addr_inc_en_i(inc_en),
      .reg_rd_data_i(rd_data), .serial_data_o(d_o), .serial_data_oe_o(d_oe), .serial_out_o(so),
      .serial_out_oe_o(so_oe), .reg_req_o(req), .spi_mode_o(spi_mode), .i2c_addressed_o(addressed));
   ssp_host_model host (.clock_i(clock), .data_pad_i(data_pad), .out_pad_i(out_pad), .clk_pad_o(scl),
      .data_o(m_data), .cs_o(cs));
   function automatic logic [7:0] bank(input logic [6:0] a);
      return {a, 1'b0} ^ 8'h5A;
   endfunction : bank
   // Bank model; junk outside the answer cycle so late sampling shows
   always @(posedge clock) begin
      rd_data <= req.rd ? bank(req.addr) : 8'($random(seed));
      if (req.wr) wq.push_back({1'b0, req.addr, req.data});
      if (req.rd) rq.push_back(req.addr);
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic report_and_stop();
      $display("Checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      logic [7:0] rx;
      logic ack;
      logic [7:0] d [0:2];
      logic [6:0] a;
      logic [6:0] ridx [0:2];
      ridx = '{7'h2B, 7'h2C, 7'h28};
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      repeat (8) @(negedge clock);
      // Two-wire write of two bytes over the top index
      foreach (d[i]) d[i] = 8'($random(seed));
      host.i2c_start();
      host.i2c_byte(8'hBA, 1'b1, rx, ack);
      check("addr ack", ack, 1'h0);
      host.i2c_byte(8'h7F, 1'b1, rx, ack);
      check("index ack", ack, 1'h0);
      for (int i = 0; i < 2; i++) begin
         host.i2c_byte(d[i], 1'b1, rx, ack);
         check("data ack", ack, 1'h0);
      end
      host.i2c_stop();
      check("wr count", 16'(wq.size()), 16'h0002);
      check("wr first", wq.pop_front(), {8'h7F, d[0]});
      check("wr second", wq.pop_front(), {8'h00, d[1]});
      // Incrementing read with repeated start, select low, wrap at the end
      sel = 1'b0;
      inc_en = 1'b0;
      host.i2c_start();
      host.i2c_byte(8'hB8, 1'b1, rx, ack);
      host.i2c_byte(8'hAB, 1'b1, rx, ack);
      host.i2c_start();
      host.i2c_byte(8'hB9, 1'b1, rx, ack);
      check("read addr ack", ack, 1'h0);
      check("addressed", addressed, 1'h1);
      for (int i = 0; i < 3; i++) begin
         host.i2c_byte(8'hFF, i == 2, rx, ack);
         check("read data", rx, bank(ridx[i]));
      end
      host.i2c_stop();
      check("rd count", 16'(rq.size()), 16'h0003);
      // Other address stays unanswered
      host.i2c_start();
      host.i2c_byte(8'hBA, 1'b1, rx, ack);
      check("foreign ack", ack, 1'h1);
      check("not addressed", addressed, 1'h0);
      host.i2c_stop();
      // Standard-mode rate
      host.q = 312;
      host.i2c_start();
      host.i2c_byte(8'hB8, 1'b1, rx, ack);
      check("slow ack", ack, 1'h0);
      host.i2c_stop();
      host.q = 80;
      // Random SPI two-byte writes, increment on or off
      for (int k = 0; k < 4; k++) begin
         wq.delete();
         a = 7'($random(seed));
         inc_en = 1'($random(seed));
         foreach (d[i]) d[i] = 8'($random(seed));
         host.spi_begin();
         host.spi_byte({1'b0, a}, 1'b0, rx);
         host.spi_byte(d[0], 1'b0, rx);
         host.spi_byte(d[1], 1'b0, rx);
         host.spi_end();
         check("spi wr first", wq.pop_front(), {1'b0, a, d[0]});
         check("spi wr second", wq.pop_front(), {1'b0, a + 7'(inc_en), d[1]});
         check("spi no two-wire", addressed, 1'h0);
      end
      // SPI reads: four-wire on the output pad, then three-wire on the data pad
      inc_en = 1'b1;
      for (int w = 0; w < 2; w++) begin
         three_w = 1'(w);
         host.spi_begin();
         host.spi_byte(8'hAB, 1'b0, rx);
         for (int i = 0; i < 3; i++) begin
            host.spi_byte(8'hFF, three_w, rx);
            check("spi read", rx, bank(ridx[i]));
         end
         host.spi_end();
      end
      three_w = 1'b0;
      repeat (8) @(negedge clock);
      report_and_stop();
   end
   // Run needs about 48500 cycles
   initial begin
      repeat (90000) @(posedge clock);
      errors++;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
